// ==== bench/lusdm_framer_model.sv ====
`timescale 1ns/1ps

module lusdm_framer_model (
  // Clock
  input wire logic aclk,
  // Pacing and fault control
  input wire logic slow,
  input wire logic [7:0] quiet,
  // Transmit side
  output logic [7:0] tx_clock,
  output logic [7:0] tx_pulse
);
  logic ph = 1'h0;

  initial begin
    tx_clock = 8'h00;
    tx_pulse = 8'h00;
  end

  // Slow mode stretches each clock phase to two cycles
  always @(posedge aclk) begin
    ph <= ~ph;
    if (!slow || ph) begin
      tx_clock <= ~tx_clock;
      // Data moves as the clock falls so the rising edge sees it settled
      if (tx_clock[0]) tx_pulse <= ~quiet;
    end
  end
endmodule

// ==== bench/lusdm_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end

module lusdm_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, slow;
  logic host_mode, gauge_select, rail_format_select, line_code_select;
  logic rx_term_select, tx_term_select, incircuit_tristate_n;
  logic awready, wready, bvalid, arready, rvalid, irq, impedance_reserved;
  logic [7:0] awaddr, araddr, quiet, tx_clock, tx_pulse, driver_fail_flag;
  logic [7:0] driver_fail_flag_oe, gauge_26, single_rail, hdb3_enable;
  logic [7:0] rx_term_internal, tx_term_internal, impedance_75, impedance_120;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, impedance_code, wr_resp;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot;
  int mismatches = 0;
  int comparisons = 0;

  lusdm_top DUT (.*);
  lusdm_framer_model u_framer (.*);

  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic rst(input int n);
    aresetn <= 1'h0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    wr_resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    `CHK(rdata, e)
    `CHK(rresp, er)
  endtask

  // Generous bound: the long resets alone take about 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, slow, host_mode, gauge_select} <= 8'h00;
    {rail_format_select, line_code_select, rx_term_select, tx_term_select} <= 4'h0;
    {awaddr, araddr, quiet, wdata, impedance_code} <= 58'h0;
    {awprot, arprot, wstrb} <= 10'h00f;
    incircuit_tristate_n <= 1'h1;
    rst(2);
    wr(8'h14, 32'h0000_003c);
    rst(1000);
    rd(8'h14, 32'h0000_003c, 2'h0);
    rst(1001);
    rd(8'h14, 32'h0000_0000, 2'h0);
    rd(8'h24, 32'h0000_0000, 2'h0);
    for (int i = 0; i < 128; i++) begin
      {rail_format_select, line_code_select, gauge_select, rx_term_select, tx_term_select,
        impedance_code} <= i[6:0];
      repeat (2) @(posedge aclk);
      `CHK(single_rail, {8{i[6]}})
      `CHK(hdb3_enable & {8{i[6]}}, {8{i[6] & i[5]}})
      `CHK(gauge_26, {8{i[4]}})
      `CHK(rx_term_internal, {8{i[3]}})
      `CHK(tx_term_internal, {8{i[2]}})
      `CHK({impedance_75, impedance_120}, {{8{i[1:0] == 2'h2}}, {8{i[1:0] == 2'h3}}})
      `CHK(impedance_reserved, !i[1])
    end
    incircuit_tristate_n <= 1'h0;
    @(posedge aclk);
    `CHK(driver_fail_flag_oe, 8'h00)
    incircuit_tristate_n <= 1'h1;
    host_mode <= 1'h1;
    rx_term_select <= 1'h1;
    wr(8'h04, 32'h0000_00a5);
    `CHK(wr_resp, 2'h0)
    repeat (2) @(posedge aclk);
    `CHK(rx_term_internal, 8'ha5)
    rd(8'h28, 32'h0000_00a5, 2'h0);
    wr(8'h00, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    `CHK(rx_term_internal, 8'hff)
    rx_term_select <= 1'h0;
    repeat (2) @(posedge aclk);
    `CHK(rx_term_internal, 8'h00)
    wr(8'h40, 32'h0000_00ff);
    `CHK(wr_resp, 2'h2)
    wr(8'h0c, 32'h0000_000f);
    wr(8'h10, 32'h0000_0033);
    repeat (2) @(posedge aclk);
    `CHK(single_rail, 8'h0f)
    `CHK(hdb3_enable, 8'h03)
    rd(8'h40, 32'h0000_0000, 2'h2);
    rd(8'h20, 32'h0000_0000, 2'h0);
    wr(8'h24, 32'h0000_00ff);
    quiet <= 8'h55;
    repeat (250) @(posedge aclk);
    `CHK(driver_fail_flag, 8'h00)
    repeat (20) @(posedge aclk);
    `CHK(driver_fail_flag, 8'h55)
    `CHK(irq, 1'h1)
    rd(8'h1c, 32'h0000_0055, 2'h0);
    wr(8'h24, 32'h0000_0000);
    `CHK(irq, 1'h0)
    wr(8'h24, 32'h0000_00ff);
    wr(8'h20, 32'h0000_00ff);
    `CHK(irq, 1'h0)
    `CHK(driver_fail_flag, 8'h55)
    slow <= 1'h1;
    quiet <= 8'h00;
    repeat (12) @(posedge aclk);
    `CHK(driver_fail_flag, 8'h00)
    stop_test();
  end
endmodule

// ==== bench/lusdm_top_sva.sv ====
`timescale 1ns/1ps

module lusdm_top_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Straps
  input wire logic host_mode,
  input wire logic gauge_select,
  input wire logic rail_format_select,
  input wire logic line_code_select,
  input wire logic rx_term_select,
  input wire logic tx_term_select,
  input wire logic [1:0] impedance_code,
  input wire logic incircuit_tristate_n,
  // Transmit side
  input wire logic [7:0] tx_clock,
  input wire logic [7:0] tx_pulse,
  // Observed outputs
  input wire logic [7:0] driver_fail_flag,
  input wire logic [7:0] driver_fail_flag_oe,
  input wire logic [7:0] gauge_26,
  input wire logic [7:0] single_rail,
  input wire logic [7:0] hdb3_enable,
  input wire logic [7:0] rx_term_internal,
  input wire logic [7:0] tx_term_internal,
  input wire logic [7:0] impedance_75,
  input wire logic [7:0] impedance_120,
  input wire logic impedance_reserved
);
  logic hw_ff;
  logic clk0_ff;
  logic [9:0] gap_ff;
  logic pulse_edge;

  // Channel 0 stands for all; the strap checks cover the other seven
  assign pulse_edge = tx_clock[0] && !clk0_ff && tx_pulse[0];

  always_ff @(posedge aclk) begin
    hw_ff <= aresetn && !host_mode;
    clk0_ff <= tx_clock[0];
  end

  // Cycles since the last pulsed edge, saturating; reset counts as a pulse one cycle back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_ff <= 10'h001;
    end else if (pulse_edge) begin
      gap_ff <= 10'h000;
    end else if (gap_ff != 10'h3ff) begin
      gap_ff <= gap_ff + 10'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rail;
    hw_ff |-> single_rail == {8{$past(rail_format_select)}};
  endproperty
  a_rail: assert property (p_rail) else $error("rail format wrong");

  property p_code;
    hw_ff && $past(rail_format_select) |-> hdb3_enable == {8{$past(line_code_select)}};
  endproperty
  a_code: assert property (p_code) else $error("line code wrong");

  property p_gauge;
    hw_ff |-> gauge_26 == {8{$past(gauge_select)}};
  endproperty
  a_gauge: assert property (p_gauge) else $error("gauge wrong");

  property p_rxterm;
    hw_ff |-> rx_term_internal == {8{$past(rx_term_select)}};
  endproperty
  a_rxterm: assert property (p_rxterm) else $error("rx termination wrong");

  property p_txterm;
    hw_ff |-> tx_term_internal == {8{$past(tx_term_select)}};
  endproperty
  a_txterm: assert property (p_txterm) else $error("tx termination wrong");

  property p_imp;
    hw_ff |-> impedance_75 == {8{$past(impedance_code) == 2'h2}}
      && impedance_120 == {8{$past(impedance_code) == 2'h3}}
      && impedance_reserved == !$past(impedance_code[1]);
  endproperty
  a_imp: assert property (p_imp) else $error("impedance wrong");

  property p_oe;
    driver_fail_flag_oe == {8{incircuit_tristate_n}};
  endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");

  property p_rise;
    $rose(driver_fail_flag[0]) |-> gap_ff >= 10'h103;
  endproperty
  a_rise: assert property (p_rise) else $error("fail flag too early");

  property p_fall;
    $fell(driver_fail_flag[0]) |-> gap_ff == 10'h001;
  endproperty
  a_fall: assert property (p_fall) else $error("fail flag fell without pulse");

  c_rise: cover property ($rose(driver_fail_flag[0]));
  c_fall: cover property ($fell(driver_fail_flag[0]));
  c_imp120: cover property (hw_ff && impedance_120[0]);
endmodule

bind lusdm_top lusdm_top_sva u_sva (.*);

// ==== hdl/lusdm_consts.svh ====
`ifndef LUSDM_CONSTS_SVH
`define LUSDM_CONSTS_SVH

// Timing
`define LUSDM_CLK_NS 10
`define LUSDM_RST_MIN_NS 10000
`define LUSDM_RST_CYC ((`LUSDM_RST_MIN_NS + `LUSDM_CLK_NS - 1) / `LUSDM_CLK_NS)
`define LUSDM_DRV_LIMIT 8'h80

// Register byte offsets
`define LUSDM_OFF_GLB_CTRL 8'h00
`define LUSDM_OFF_RX_TERM 8'h04
`define LUSDM_OFF_TX_TERM 8'h08
`define LUSDM_OFF_RAIL 8'h0C
`define LUSDM_OFF_LINE_CODE 8'h10
`define LUSDM_OFF_GAUGE 8'h14
`define LUSDM_OFF_DRV_FAIL 8'h18
`define LUSDM_OFF_INT_STATUS 8'h1C
`define LUSDM_OFF_INT_CLEAR 8'h20
`define LUSDM_OFF_INT_ENABLE 8'h24
`define LUSDM_OFF_EFF_RX_TERM 8'h28

// Global control fields
`define LUSDM_GLB_OVR_BIT 0
`define LUSDM_GLB_IMP_LSB 1
`define LUSDM_GLB_IMP_MSB 2

// Reset values
`define LUSDM_RST_CHAN 8'h00
`define LUSDM_RST_GLB 8'h00

// Impedance codes
`define LUSDM_IMP_75 2'h2
`define LUSDM_IMP_120 2'h3

// Bus responses
`define LUSDM_RESP_OKAY 2'h0
`define LUSDM_RESP_SLVERR 2'h2

`endif

// ==== hdl/lusdm_drv_mon.sv ====
`timescale 1ns/1ps
`include "lusdm_consts.svh"

module lusdm_drv_mon (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Channel events
  lusdm_mon_if.mon mon
);

  logic [7:0] cnt_ff [8];
  logic [7:0] fail_ff;

  // Counts transmit clock edges without a pulse; saturates one past the limit
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (!aresetn) begin
        cnt_ff[i] <= 8'h00;
      end else if (mon.tx_edge[i]) begin
        if (mon.tx_pulse[i]) begin
          cnt_ff[i] <= 8'h00;
        end else if (cnt_ff[i] <= `LUSDM_DRV_LIMIT) begin
          cnt_ff[i] <= cnt_ff[i] + 8'h01;
        end
      end
    end
  end

  // Raised only on transmit clock edges and cleared on them or by reset, so outside reset
  // the flag spans at least one whole transmit clock cycle
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 8; i++) begin
      if (!aresetn) begin
        fail_ff[i] <= 1'b0;
      end else if (mon.tx_edge[i]) begin
        if (fail_ff[i]) begin
          fail_ff[i] <= !mon.tx_pulse[i];
        end else if (!mon.tx_pulse[i] && cnt_ff[i] == `LUSDM_DRV_LIMIT) begin
          fail_ff[i] <= 1'b1;
        end
      end
    end
  end

  assign mon.fail = fail_ff;

endmodule

// ==== hdl/lusdm_mon_if.sv ====
`timescale 1ns/1ps

interface lusdm_mon_if;
  logic [7:0] tx_edge;
  logic [7:0] tx_pulse;
  logic [7:0] fail;

  modport ctl (
    output tx_edge,
    output tx_pulse,
    input fail
  );

  modport mon (
    input tx_edge,
    input tx_pulse,
    output fail
  );
endinterface

// ==== hdl/lusdm_pkg.sv ====
package lusdm_pkg;

  typedef logic [7:0] lusdm_chan_t;
  typedef logic [7:0] lusdm_addr_t;
  typedef logic [1:0] lusdm_imp_t;

  typedef enum {
    LUSDM_BUS_IDLE,
    LUSDM_BUS_RESP
  } lusdm_bus_state_t;

endpackage

// ==== hdl/lusdm_top.sv ====
`timescale 1ns/1ps
`include "lusdm_consts.svh"

module lusdm_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Mode and strap pins
  input wire logic host_mode,
  input wire logic gauge_select,
  input wire logic rail_format_select,
  input wire logic line_code_select,
  input wire logic rx_term_select,
  input wire logic tx_term_select,
  input wire logic [1:0] impedance_code,
  input wire logic incircuit_tristate_n,
  // Transmit side per channel
  input wire logic [7:0] tx_clock,
  input wire logic [7:0] tx_pulse,
  // Driver monitor pins
  output logic [7:0] driver_fail_flag,
  output logic [7:0] driver_fail_flag_oe,
  // Line configuration, per channel except the single impedance_reserved bit
  output logic [7:0] gauge_26,
  output logic [7:0] single_rail,
  output logic [7:0] hdb3_enable,
  output logic [7:0] rx_term_internal,
  output logic [7:0] tx_term_internal,
  output logic [7:0] impedance_75,
  output logic [7:0] impedance_120,
  output logic impedance_reserved,
  // Interrupt
  output logic irq
);

  function automatic logic addr_is(input lusdm_pkg::lusdm_addr_t a,
                                   input lusdm_pkg::lusdm_addr_t off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction

  function automatic lusdm_pkg::lusdm_chan_t pick(input logic host,
                                                   input lusdm_pkg::lusdm_chan_t reg_val,
                                                   input logic pin);
    pick = host ? reg_val : {8{pin}};
  endfunction

  // Long reset detection
  logic [9:0] rst_cnt_ff;
  logic long_rst;

  // Software registers
  logic [7:0] glb_ctrl_ff;
  lusdm_pkg::lusdm_chan_t rx_term_reg_ff;
  lusdm_pkg::lusdm_chan_t tx_term_reg_ff;
  lusdm_pkg::lusdm_chan_t rail_reg_ff;
  lusdm_pkg::lusdm_chan_t code_reg_ff;
  lusdm_pkg::lusdm_chan_t gauge_reg_ff;
  lusdm_pkg::lusdm_chan_t int_status_ff;
  lusdm_pkg::lusdm_chan_t int_enable_ff;

  // Bus state
  lusdm_pkg::lusdm_bus_state_t wr_state_ff;
  lusdm_pkg::lusdm_bus_state_t rd_state_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic wr_take;
  logic rd_take;
  logic wr_known;
  logic [31:0] nxt_rdata;
  logic [1:0] nxt_rresp;

  // Monitor and effective configuration
  logic [7:0] tx_clock_prev_ff;
  logic [7:0] fail_prev_ff;
  logic [7:0] fail_rise;
  lusdm_pkg::lusdm_chan_t eff_rx_term;
  lusdm_pkg::lusdm_imp_t eff_imp;
  logic [7:0] drv_fail_ff;
  logic [7:0] gauge_ff;
  logic [7:0] rail_ff;
  logic [7:0] hdb3_ff;
  logic [7:0] rx_term_ff;
  logic [7:0] tx_term_ff;
  logic [7:0] imp75_ff;
  logic [7:0] imp120_ff;
  logic imp_res_ff;

  lusdm_mon_if mon_bus ();

  // A short glitch on reset restarts the bus, the monitors and the output registers; the
  // programmed configuration survives until reset has been held long enough
  always_ff @(posedge aclk) begin
    if (aresetn) begin
      rst_cnt_ff <= 10'h000;
    end else if (rst_cnt_ff != 10'(`LUSDM_RST_CYC)) begin
      rst_cnt_ff <= rst_cnt_ff + 10'h001;
    end
  end

  assign long_rst = !aresetn && (rst_cnt_ff == 10'(`LUSDM_RST_CYC));

  // Write channel: address and data are taken together in one beat
  assign wr_take = awvalid && wvalid && (wr_state_ff == lusdm_pkg::LUSDM_BUS_IDLE);
  assign awready = wr_take;
  assign wready = wr_take;
  assign bvalid = (wr_state_ff == lusdm_pkg::LUSDM_BUS_RESP);
  assign bresp = bresp_ff;

  always_comb begin
    wr_known = addr_is(awaddr, `LUSDM_OFF_GLB_CTRL) || addr_is(awaddr, `LUSDM_OFF_RX_TERM)
      || addr_is(awaddr, `LUSDM_OFF_TX_TERM) || addr_is(awaddr, `LUSDM_OFF_RAIL)
      || addr_is(awaddr, `LUSDM_OFF_LINE_CODE) || addr_is(awaddr, `LUSDM_OFF_GAUGE)
      || addr_is(awaddr, `LUSDM_OFF_INT_CLEAR) || addr_is(awaddr, `LUSDM_OFF_INT_ENABLE);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= lusdm_pkg::LUSDM_BUS_IDLE;
      bresp_ff <= `LUSDM_RESP_OKAY;
    end else begin
      case (wr_state_ff)
        lusdm_pkg::LUSDM_BUS_IDLE: begin
          if (wr_take) begin
            wr_state_ff <= lusdm_pkg::LUSDM_BUS_RESP;
            bresp_ff <= wr_known ? `LUSDM_RESP_OKAY : `LUSDM_RESP_SLVERR;
          end
        end
        lusdm_pkg::LUSDM_BUS_RESP: begin
          if (bready) begin
            wr_state_ff <= lusdm_pkg::LUSDM_BUS_IDLE;
          end
        end
        default: begin
          wr_state_ff <= lusdm_pkg::LUSDM_BUS_IDLE;
        end
      endcase
    end
  end

  // Configuration registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (long_rst) begin
      glb_ctrl_ff <= `LUSDM_RST_GLB;
      rx_term_reg_ff <= `LUSDM_RST_CHAN;
      tx_term_reg_ff <= `LUSDM_RST_CHAN;
      rail_reg_ff <= `LUSDM_RST_CHAN;
      code_reg_ff <= `LUSDM_RST_CHAN;
      gauge_reg_ff <= `LUSDM_RST_CHAN;
      int_enable_ff <= `LUSDM_RST_CHAN;
    end else if (wr_take && wstrb[0]) begin
      if (addr_is(awaddr, `LUSDM_OFF_GLB_CTRL)) begin
        glb_ctrl_ff <= wdata[7:0];
      end
      if (addr_is(awaddr, `LUSDM_OFF_RX_TERM)) begin
        rx_term_reg_ff <= wdata[7:0];
      end
      if (addr_is(awaddr, `LUSDM_OFF_TX_TERM)) begin
        tx_term_reg_ff <= wdata[7:0];
      end
      if (addr_is(awaddr, `LUSDM_OFF_RAIL)) begin
        rail_reg_ff <= wdata[7:0];
      end
      if (addr_is(awaddr, `LUSDM_OFF_LINE_CODE)) begin
        code_reg_ff <= wdata[7:0];
      end
      if (addr_is(awaddr, `LUSDM_OFF_GAUGE)) begin
        gauge_reg_ff <= wdata[7:0];
      end
      if (addr_is(awaddr, `LUSDM_OFF_INT_ENABLE)) begin
        int_enable_ff <= wdata[7:0];
      end
    end
  end

  // Sticky driver-fail events; a new event beats a clear in the same cycle
  assign fail_rise = mon_bus.fail & ~fail_prev_ff;

  always_ff @(posedge aclk) begin
    if (long_rst) begin
      int_status_ff <= `LUSDM_RST_CHAN;
    end else if (wr_take && wstrb[0] && addr_is(awaddr, `LUSDM_OFF_INT_CLEAR)) begin
      int_status_ff <= (int_status_ff & ~wdata[7:0]) | fail_rise;
    end else begin
      int_status_ff <= int_status_ff | fail_rise;
    end
  end

  assign irq = |(int_status_ff & int_enable_ff);

  // Read channel
  assign rd_take = arvalid && (rd_state_ff == lusdm_pkg::LUSDM_BUS_IDLE);
  assign arready = (rd_state_ff == lusdm_pkg::LUSDM_BUS_IDLE);
  assign rvalid = (rd_state_ff == lusdm_pkg::LUSDM_BUS_RESP);
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `LUSDM_RESP_OKAY;
    if (addr_is(araddr, `LUSDM_OFF_GLB_CTRL)) begin
      nxt_rdata[7:0] = glb_ctrl_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_RX_TERM)) begin
      nxt_rdata[7:0] = rx_term_reg_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_TX_TERM)) begin
      nxt_rdata[7:0] = tx_term_reg_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_RAIL)) begin
      nxt_rdata[7:0] = rail_reg_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_LINE_CODE)) begin
      nxt_rdata[7:0] = code_reg_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_GAUGE)) begin
      nxt_rdata[7:0] = gauge_reg_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_DRV_FAIL)) begin
      nxt_rdata[7:0] = mon_bus.fail;
    end else if (addr_is(araddr, `LUSDM_OFF_INT_STATUS)) begin
      nxt_rdata[7:0] = int_status_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_INT_ENABLE)) begin
      nxt_rdata[7:0] = int_enable_ff;
    end else if (addr_is(araddr, `LUSDM_OFF_EFF_RX_TERM)) begin
      nxt_rdata[7:0] = eff_rx_term;
    end else if (addr_is(araddr, `LUSDM_OFF_INT_CLEAR)) begin
      nxt_rdata = 32'h0000_0000;
    end else begin
      nxt_rresp = `LUSDM_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= lusdm_pkg::LUSDM_BUS_IDLE;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `LUSDM_RESP_OKAY;
    end else begin
      case (rd_state_ff)
        lusdm_pkg::LUSDM_BUS_IDLE: begin
          if (rd_take) begin
            rd_state_ff <= lusdm_pkg::LUSDM_BUS_RESP;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
          end
        end
        lusdm_pkg::LUSDM_BUS_RESP: begin
          if (rready) begin
            rd_state_ff <= lusdm_pkg::LUSDM_BUS_IDLE;
          end
        end
        default: begin
          rd_state_ff <= lusdm_pkg::LUSDM_BUS_IDLE;
        end
      endcase
    end
  end

  // Transmit clocks arrive synchronous to aclk, so a plain edge detect serves
  // The previous level follows the pin through reset, so release shows no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_clock_prev_ff <= tx_clock;
      fail_prev_ff <= 8'h00;
    end else begin
      tx_clock_prev_ff <= tx_clock;
      fail_prev_ff <= mon_bus.fail;
    end
  end

  assign mon_bus.tx_edge = tx_clock & ~tx_clock_prev_ff;
  assign mon_bus.tx_pulse = tx_pulse;

  lusdm_drv_mon u_drv_mon (
    .aclk(aclk),
    .aresetn(aresetn),
    .mon(mon_bus.mon)
  );

  // Effective configuration
  always_comb begin
    if (host_mode && glb_ctrl_ff[`LUSDM_GLB_OVR_BIT]) begin
      eff_rx_term = {8{rx_term_select}};
    end else begin
      eff_rx_term = pick(host_mode, rx_term_reg_ff, rx_term_select);
    end
  end

  assign eff_imp = host_mode ? glb_ctrl_ff[`LUSDM_GLB_IMP_MSB:`LUSDM_GLB_IMP_LSB]
                             : impedance_code;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_fail_ff <= 8'h00;
      gauge_ff <= 8'h00;
      rail_ff <= 8'h00;
      hdb3_ff <= 8'h00;
      rx_term_ff <= 8'h00;
      tx_term_ff <= 8'h00;
      imp75_ff <= 8'h00;
      imp120_ff <= 8'h00;
      imp_res_ff <= 1'b1;
    end else begin
      drv_fail_ff <= mon_bus.fail;
      gauge_ff <= pick(host_mode, gauge_reg_ff, gauge_select);
      rail_ff <= pick(host_mode, rail_reg_ff, rail_format_select);
      // Coding is only ours to do in single-rail format
      hdb3_ff <= pick(host_mode, rail_reg_ff, rail_format_select)
        & pick(host_mode, code_reg_ff, line_code_select);
      rx_term_ff <= eff_rx_term;
      tx_term_ff <= pick(host_mode, tx_term_reg_ff, tx_term_select);
      imp75_ff <= {8{eff_imp == `LUSDM_IMP_75}};
      imp120_ff <= {8{eff_imp == `LUSDM_IMP_120}};
      imp_res_ff <= !eff_imp[1];
    end
  end

  // Test input tristates only the driver fail flag pins without disturbing the internal state
  assign driver_fail_flag = drv_fail_ff;
  assign driver_fail_flag_oe = {8{incircuit_tristate_n}};
  assign gauge_26 = gauge_ff;
  assign single_rail = rail_ff;
  assign hdb3_enable = hdb3_ff;
  assign rx_term_internal = rx_term_ff;
  assign tx_term_internal = tx_term_ff;
  assign impedance_75 = imp75_ff;
  assign impedance_120 = imp120_ff;
  assign impedance_reserved = imp_res_ff;

endmodule
